// *** hdl/nibdir_pkg.sv ***
// Package for the nibble-exchange / direction-load execution block.
// Assumes a 14-bit instruction word and an 8-bit data path.
package nibdir_pkg;

   // Instruction word layout
   localparam int INSTR_W = 14;
   localparam int PREFIX_HI = 13;
   localparam int PREFIX_LO = 12;
   localparam int FIELD_HI = 11;
   localparam int FIELD_LO = 8;
   localparam int DEST_BIT = 7;
   localparam int ADDR_HI = 6;
   localparam int ADDR_LO = 0;
   localparam int DIRSEL_HI = 2;
   localparam int DIRSEL_LO = 0;
   localparam int DIRLOAD_UPPER_LO = 3;

   // Opcode patterns
   localparam logic [1:0] OP_PREFIX_BYTE = 2'h0;
   localparam logic [3:0] OP_FIELD_SWAP = 4'hE;
   localparam logic [10:0] OP_DIRLOAD_UPPER = 11'h00C;
   localparam logic [2:0] DIRSEL_MIN = 3'h5;
   localparam logic [2:0] DIRSEL_MAX = 3'h7;

   // Direction registers sit in the upper bank of the register file
   localparam logic [7:0] DIR_REG_BASE = 8'h80;

   // Reset values
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] ADDR_RST = 8'h00;
   localparam logic [1:0] SYNC_RST = 2'h0;

   // Four-phase instruction cycle
   typedef enum logic [1:0] {
      PH_Q1 = 2'b00,
      PH_Q2 = 2'b01,
      PH_Q3 = 2'b10,
      PH_Q4 = 2'b11
   } phase_t;

   // Operation in flight
   typedef enum logic [1:0] {
      EX_NONE = 2'b00,
      EX_SWAP = 2'b01,
      EX_DIRLOAD = 2'b10,
      EX_BADSEL = 2'b11
   } exec_t;

endpackage : nibdir_pkg

// *** hdl/nibble_swap_tristate_load_exec.sv ***
// Execution slice for the nibble exchange and the direction-register load.
// Sits between the instruction decoder and the register file; the register
// file answers a read combinationally in the phase the read is issued.
`timescale 1ns/10ps
`default_nettype none

module nibble_swap_tristate_load_exec (
   // Clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RESETN_IN,
   // Instruction from decoder, sampled in Q1
   input wire logic [13:0] INSTR_IN,
   input wire logic INSTR_VALID_IN,
   input wire logic BANK_IN,
   // Accumulator and register file read data
   input wire logic [7:0] ACC_IN,
   input wire logic [7:0] RF_RD_DATA_IN,
   // Register file read port
   output logic RF_RD_EN_OUT,
   output logic [7:0] RF_RD_ADDR_OUT,
   // Register file write port
   output logic RF_WR_EN_OUT,
   output logic [7:0] RF_WR_ADDR_OUT,
   output logic [7:0] RF_WR_DATA_OUT,
   // Accumulator write port
   output logic ACC_WR_EN_OUT,
   output logic [7:0] ACC_WR_DATA_OUT,
   // Status and sequencing
   output logic STATUS_WR_EN_OUT,
   output logic [1:0] PHASE_OUT,
   output logic DONE_OUT,
   output logic BAD_OPERAND_OUT
);

   typedef struct packed {
      nibdir_pkg::phase_t phase;
      nibdir_pkg::exec_t op;
      logic dest;
      logic [7:0] addr;
      logic [7:0] result;
      logic rd_en;
      logic wr_en;
      logic [7:0] wr_addr;
      logic [7:0] wr_data;
      logic acc_en;
      logic [7:0] acc_data;
      logic done;
      logic bad;
      logic flag_wr;
   } state_t;

   // Idle state; strobes low so nothing is written while reset releases
   localparam state_t ST_IDLE = '{
      phase: nibdir_pkg::PH_Q1,
      op: nibdir_pkg::EX_NONE,
      dest: 1'b0,
      addr: nibdir_pkg::ADDR_RST,
      result: nibdir_pkg::DATA_RST,
      rd_en: 1'b0,
      wr_en: 1'b0,
      wr_addr: nibdir_pkg::ADDR_RST,
      wr_data: nibdir_pkg::DATA_RST,
      acc_en: 1'b0,
      acc_data: nibdir_pkg::DATA_RST,
      done: 1'b0,
      bad: 1'b0,
      flag_wr: 1'b0
   };

   state_t st_reg;
   state_t st_next;
   logic [1:0] sync_reg;
   logic rst_n;
   // Read data with its nibbles exchanged
   wire logic [7:0] rd_swapped;

   function automatic logic is_swap(input logic [13:0] w);
      is_swap = (w[nibdir_pkg::PREFIX_HI:nibdir_pkg::PREFIX_LO] == nibdir_pkg::OP_PREFIX_BYTE)
         && (w[nibdir_pkg::FIELD_HI:nibdir_pkg::FIELD_LO] == nibdir_pkg::OP_FIELD_SWAP);
   endfunction : is_swap

   function automatic logic is_dirload(input logic [13:0] w);
      is_dirload = (w[nibdir_pkg::INSTR_W-1:nibdir_pkg::DIRLOAD_UPPER_LO]
         == nibdir_pkg::OP_DIRLOAD_UPPER);
   endfunction : is_dirload

   // Select outside 5..7 names no direction register
   function automatic logic dirsel_valid(input logic [2:0] s);
      dirsel_valid = (s >= nibdir_pkg::DIRSEL_MIN) && (s <= nibdir_pkg::DIRSEL_MAX);
   endfunction : dirsel_valid

   // Direction registers keep their ordinary register-file address
   function automatic logic [7:0] dir_reg_addr(input logic [2:0] s);
      dir_reg_addr = nibdir_pkg::DIR_REG_BASE | {5'h00, s};
   endfunction : dir_reg_addr

   // Each bit moves to the same position in the other nibble
   for (genvar g = 0; g < 4; g++) begin : g_xchg
      assign rd_swapped[g] = RF_RD_DATA_IN[g + 4];
      assign rd_swapped[g + 4] = RF_RD_DATA_IN[g];
   end

   // Reset released through two flops so deassertion is clean
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         sync_reg <= nibdir_pkg::SYNC_RST;
      end else begin
         sync_reg <= {sync_reg[0], 1'b1};
      end
   end
   assign rst_n = sync_reg[1];

   // One pass per phase; the word is only looked at in Q1
   always_comb begin
      logic [2:0] sel;
      sel = INSTR_IN[nibdir_pkg::DIRSEL_HI:nibdir_pkg::DIRSEL_LO];
      st_next = st_reg;
      // Strobes are single-cycle pulses: the read in Q2, writes, done and bad in Q4
      st_next.rd_en = 1'b0;
      st_next.wr_en = 1'b0;
      st_next.acc_en = 1'b0;
      st_next.done = 1'b0;
      st_next.bad = 1'b0;
      st_next.flag_wr = 1'b0;
      case (st_reg.phase)
         nibdir_pkg::PH_Q1: begin
            st_next.phase = nibdir_pkg::PH_Q2;
            // Idle or foreign words leave no operation, so Q2..Q4 stay quiet
            st_next.op = nibdir_pkg::EX_NONE;
            st_next.dest = INSTR_IN[nibdir_pkg::DEST_BIT];
            if (INSTR_VALID_IN && is_swap(INSTR_IN)) begin
               st_next.op = nibdir_pkg::EX_SWAP;
               st_next.addr = {BANK_IN, INSTR_IN[nibdir_pkg::ADDR_HI:nibdir_pkg::ADDR_LO]};
               st_next.rd_en = 1'b1;
            end else if (INSTR_VALID_IN && is_dirload(INSTR_IN)) begin
               // Selects outside 5..7 are dropped, no register touched
               if (dirsel_valid(sel)) begin
                  st_next.op = nibdir_pkg::EX_DIRLOAD;
               end else begin
                  st_next.op = nibdir_pkg::EX_BADSEL;
               end
               // Target is the register-file copy, so direct access still works
               st_next.addr = dir_reg_addr(sel);
            end
         end
         nibdir_pkg::PH_Q2: begin
            st_next.phase = nibdir_pkg::PH_Q3;
            // Register file answers in this phase, so the data is taken here
            if (st_reg.op == nibdir_pkg::EX_SWAP) begin
               st_next.result = rd_swapped;
            end
         end
         nibdir_pkg::PH_Q3: begin
            st_next.phase = nibdir_pkg::PH_Q4;
            case (st_reg.op)
               nibdir_pkg::EX_SWAP: begin
                  if (st_reg.dest) begin
                     st_next.wr_en = 1'b1;
                     st_next.wr_addr = st_reg.addr;
                     st_next.wr_data = st_reg.result;
                  end else begin
                     st_next.acc_en = 1'b1;
                     st_next.acc_data = st_reg.result;
                  end
                  st_next.done = 1'b1;
               end
               nibdir_pkg::EX_DIRLOAD: begin
                  // Accumulator taken late, so an earlier write to it is seen
                  st_next.wr_en = 1'b1;
                  st_next.wr_addr = st_reg.addr;
                  st_next.wr_data = ACC_IN;
                  st_next.done = 1'b1;
               end
               nibdir_pkg::EX_BADSEL: begin
                  // Reported only, so a stray select cannot hit another register
                  st_next.bad = 1'b1;
                  st_next.done = 1'b1;
               end
               default: begin
                  st_next.done = 1'b0;
               end
            endcase
         end
         nibdir_pkg::PH_Q4: begin
            // Next decode follows at once, so instructions run back to back
            st_next.phase = nibdir_pkg::PH_Q1;
         end
         default: begin
            st_next.phase = nibdir_pkg::PH_Q1;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK_IN or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= ST_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign RF_RD_EN_OUT = st_reg.rd_en;
   assign RF_RD_ADDR_OUT = st_reg.addr;
   assign RF_WR_EN_OUT = st_reg.wr_en;
   assign RF_WR_ADDR_OUT = st_reg.wr_addr;
   assign RF_WR_DATA_OUT = st_reg.wr_data;
   assign ACC_WR_EN_OUT = st_reg.acc_en;
   assign ACC_WR_DATA_OUT = st_reg.acc_data;
   // Neither instruction touches the flags
   assign STATUS_WR_EN_OUT = st_reg.flag_wr;
   assign PHASE_OUT = st_reg.phase;
   assign DONE_OUT = st_reg.done;
   assign BAD_OPERAND_OUT = st_reg.bad;

endmodule : nibble_swap_tristate_load_exec

`default_nettype wire

// *** tb/nibble_swap_tristate_load_exec_asserts.sv ***
// Port checks for the nibble exchange / direction load slice.
// Bound to the block; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module nibble_swap_tristate_load_exec_asserts (
   // Clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RESETN_IN,
   // Block inputs
   input wire logic [13:0] INSTR_IN,
   input wire logic INSTR_VALID_IN,
   input wire logic BANK_IN,
   input wire logic [7:0] ACC_IN,
   input wire logic [7:0] RF_RD_DATA_IN,
   // Block outputs
   input wire logic RF_RD_EN_OUT,
   input wire logic [7:0] RF_RD_ADDR_OUT,
   input wire logic RF_WR_EN_OUT,
   input wire logic [7:0] RF_WR_ADDR_OUT,
   input wire logic [7:0] RF_WR_DATA_OUT,
   input wire logic ACC_WR_EN_OUT,
   input wire logic [7:0] ACC_WR_DATA_OUT,
   input wire logic STATUS_WR_EN_OUT,
   input wire logic [1:0] PHASE_OUT,
   input wire logic DONE_OUT,
   input wire logic BAD_OPERAND_OUT
);
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   wire logic go = PHASE_OUT == 2'h0 && INSTR_VALID_IN;
   wire logic sw = go && INSTR_IN[13:8] == 6'h0E;
   wire logic ld = go && INSTR_IN[13:3] == 11'h00C;
   // Q2 read data is seen two edges before the Q4 check
   wire logic [7:0] xs = {RF_RD_DATA_IN[3:0], RF_RD_DATA_IN[7:4]};
   a_swap_acc: assert property (sw && !INSTR_IN[7] |-> ##3 ACC_WR_EN_OUT &&
      !RF_WR_EN_OUT && ACC_WR_DATA_OUT == $past(xs, 2)) else $error("acc write wrong");
   a_swap_back: assert property (sw && INSTR_IN[7] |=> RF_RD_EN_OUT ##0
      RF_RD_ADDR_OUT == {$past(BANK_IN), $past(INSTR_IN[6:0])} ##2 RF_WR_EN_OUT
      && RF_WR_DATA_OUT == $past(xs, 2) && RF_WR_ADDR_OUT == $past(RF_RD_ADDR_OUT, 2)
      && !ACC_WR_EN_OUT) else $error("write-back wrong");
   a_dir_load: assert property (ld && INSTR_IN[2:0] >= 3'h5 |-> ##3 RF_WR_EN_OUT
      && DONE_OUT && RF_WR_ADDR_OUT == {5'h10, $past(INSTR_IN[2:0], 3)}
      && RF_WR_DATA_OUT == $past(ACC_IN)) else $error("direction load wrong");
   a_bad_select: assert property (ld && INSTR_IN[2:0] < 3'h5 |-> ##3
      BAD_OPERAND_OUT && DONE_OUT && !RF_WR_EN_OUT) else $error("bad select written");
   a_phase_step: assert property (PHASE_OUT != 2'h0 |=>
      PHASE_OUT == $past(PHASE_OUT) + 2'h1) else $error("phase order broken");
   a_flags_kept: assert property (!STATUS_WR_EN_OUT &&
      (!(RF_WR_EN_OUT || ACC_WR_EN_OUT) || PHASE_OUT == 2'h3)) else $error("flag or late write");
   c_swap_acc: cover property (sw && !INSTR_IN[7]);
   c_swap_back: cover property (sw && INSTR_IN[7]);
   c_bad_load: cover property (ld && INSTR_IN[2:0] < 3'h5 ##3 BAD_OPERAND_OUT);
   c_dir_load: cover property (ld && INSTR_IN[2:0] >= 3'h5 ##3 RF_WR_EN_OUT);
endmodule : nibble_swap_tristate_load_exec_asserts
`default_nettype wire

// *** tb/nibble_swap_tristate_load_exec_tb.sv ***
// Self-checking bench for the nibble exchange / direction load slice.
// Bench plays decoder, accumulator and register file; checker is bound below.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module nibble_swap_tristate_load_exec_tb;
   logic SYS_CLK_IN = 1'b0, RESETN_IN = 1'b0, INSTR_VALID_IN = 1'b0, BANK_IN = 1'b0;
   logic [13:0] INSTR_IN = 14'h0000;
   logic [7:0] ACC_IN = 8'h00, RF_RD_DATA_IN = 8'h00, RF_RD_ADDR_OUT, RF_WR_ADDR_OUT;
   logic [7:0] RF_WR_DATA_OUT, ACC_WR_DATA_OUT;
   logic RF_RD_EN_OUT, RF_WR_EN_OUT, ACC_WR_EN_OUT, STATUS_WR_EN_OUT, DONE_OUT;
   logic BAD_OPERAND_OUT;
   logic [1:0] PHASE_OUT;
   int error_cnt = 0, total_checks = 0;
   always #4 SYS_CLK_IN = ~SYS_CLK_IN;
   nibble_swap_tristate_load_exec i_nibble_swap_tristate_load_exec (
      .SYS_CLK_IN(SYS_CLK_IN),
      .RESETN_IN(RESETN_IN),
      .INSTR_IN(INSTR_IN),
      .INSTR_VALID_IN(INSTR_VALID_IN),
      .BANK_IN(BANK_IN),
      .ACC_IN(ACC_IN),
      .RF_RD_DATA_IN(RF_RD_DATA_IN),
      .RF_RD_EN_OUT(RF_RD_EN_OUT),
      .RF_RD_ADDR_OUT(RF_RD_ADDR_OUT),
      .RF_WR_EN_OUT(RF_WR_EN_OUT),
      .RF_WR_ADDR_OUT(RF_WR_ADDR_OUT),
      .RF_WR_DATA_OUT(RF_WR_DATA_OUT),
      .ACC_WR_EN_OUT(ACC_WR_EN_OUT),
      .ACC_WR_DATA_OUT(ACC_WR_DATA_OUT),
      .STATUS_WR_EN_OUT(STATUS_WR_EN_OUT),
      .PHASE_OUT(PHASE_OUT),
      .DONE_OUT(DONE_OUT),
      .BAD_OPERAND_OUT(BAD_OPERAND_OUT)
   );
   function automatic logic [7:0] swp(input logic [7:0] v);
      return {v[3:0], v[7:4]};
   endfunction : swp
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic step;
      @(posedge SYS_CLK_IN);
      #1;
   endtask : step
   // One instruction from Q1 to Q4; returns settled in Q4
   task automatic run(input logic [13:0] op, input logic bk, input logic [7:0] rd, ac);
      logic sw, ld, ok;
      logic [15:0] wx;
      sw = op[13:8] == 6'h0E;
      ld = op[13:3] == 11'h00C;
      ok = ld && op[2:0] >= 3'h5;
      wx = sw ? {bk, op[6:0], swp(rd)} : {nibdir_pkg::DIR_REG_BASE | {5'h00, op[2:0]}, ac};
      for (int n = 0; PHASE_OUT !== 2'h0; n++) begin
         if (n > 8) begin
            error_cnt++;
            $display("MISMATCH t=%0t phase wait timed out", $time);
            tally_and_finish();
         end
         step();
      end
      INSTR_IN = op;
      BANK_IN = bk;
      INSTR_VALID_IN = 1'b1;
      step();
      // A live load word outside Q1 must be ignored
      INSTR_IN = 14'h0065;
      BANK_IN = ~bk;
      RF_RD_DATA_IN = rd;
      `CHK(RF_RD_EN_OUT, sw)
      `CHK(PHASE_OUT, 2'h1)
      if (sw) `CHK(RF_RD_ADDR_OUT, {bk, op[6:0]})
      step();
      RF_RD_DATA_IN = ~rd;
      ACC_IN = ac;
      step();
      ACC_IN = ~ac;
      `CHK({ACC_WR_EN_OUT, RF_WR_EN_OUT}, {sw && !op[7], sw && op[7] || ok})
      `CHK({DONE_OUT, BAD_OPERAND_OUT, STATUS_WR_EN_OUT}, {sw || ld, ld && !ok, 1'b0})
      `CHK(PHASE_OUT, 2'h3)
      if (sw && !op[7]) `CHK(ACC_WR_DATA_OUT, swp(rd))
      if (sw && op[7] || ok) `CHK({RF_WR_ADDR_OUT, RF_WR_DATA_OUT}, wx)
   endtask : run
   initial begin
      logic [13:0] w;
      void'($urandom(32'h1C94));
      repeat (12) @(posedge SYS_CLK_IN);
      #1;
      `CHK({PHASE_OUT, RF_WR_EN_OUT, ACC_WR_EN_OUT, DONE_OUT}, 5'h00)
      RESETN_IN = 1'b1;
      repeat (3) step();
      run(14'h0EA5, 1'b0, 8'hA5, 8'h00);
      run(14'h0E25, 1'b0, 8'hA5, 8'h3C);
      run(14'h0E85, 1'b1, 8'hFF, 8'h00);
      for (int s = 0; s < 8; s++) run({11'h00C, 3'(s)}, 1'b0, 8'h00, 8'(8'hC3 + s));
      for (int i = 0; i < 60; i++) begin
         w = {$urandom_range(2) == 0 ? 6'h0E : 6'($urandom), 8'($urandom)};
         run(w, 1'($urandom), 8'($urandom), 8'($urandom));
      end
      INSTR_VALID_IN = 1'b0;
      step();
      tally_and_finish();
   end
endmodule : nibble_swap_tristate_load_exec_tb
bind nibble_swap_tristate_load_exec nibble_swap_tristate_load_exec_asserts
   i_nibble_swap_tristate_load_exec_asserts (
      .SYS_CLK_IN(SYS_CLK_IN),
      .RESETN_IN(RESETN_IN),
      .INSTR_IN(INSTR_IN),
      .INSTR_VALID_IN(INSTR_VALID_IN),
      .BANK_IN(BANK_IN),
      .ACC_IN(ACC_IN),
      .RF_RD_DATA_IN(RF_RD_DATA_IN),
      .RF_RD_EN_OUT(RF_RD_EN_OUT),
      .RF_RD_ADDR_OUT(RF_RD_ADDR_OUT),
      .RF_WR_EN_OUT(RF_WR_EN_OUT),
      .RF_WR_ADDR_OUT(RF_WR_ADDR_OUT),
      .RF_WR_DATA_OUT(RF_WR_DATA_OUT),
      .ACC_WR_EN_OUT(ACC_WR_EN_OUT),
      .ACC_WR_DATA_OUT(ACC_WR_DATA_OUT),
      .STATUS_WR_EN_OUT(STATUS_WR_EN_OUT),
      .PHASE_OUT(PHASE_OUT),
      .DONE_OUT(DONE_OUT),
      .BAD_OPERAND_OUT(BAD_OPERAND_OUT)
   );
`default_nettype wire
